// file: verilog/ofeu_pkg.sv
`default_nettype none
package ofeu_pkg;
  // data type widths
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int POS_W  = 5;
  // request operations
  typedef enum logic [2:0] {
    OP_LOAD  = 3'h0,
    OP_REGSRC = 3'h1,
    OP_STORE = 3'h2,
    OP_FIELD = 3'h3,
    OP_FLOAT = 3'h4
  } ofeu_op_t;
  // operand sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } ofeu_size_t;
  // float formats
  typedef enum logic [1:0] {
    FP_SINGLE = 2'h0,
    FP_DOUBLE = 2'h1,
    FP_EXT    = 2'h2
  } ofeu_fpfmt_t;
  // single precision layout
  localparam int SP_SIGN   = 31;
  localparam int SP_EXP_HI = 30;
  localparam int SP_EXP_LO = 23;
  localparam int SP_FRC_HI = 22;
  // double precision layout
  localparam int DP_SIGN   = 63;
  localparam int DP_EXP_HI = 62;
  localparam int DP_EXP_LO = 52;
  localparam int DP_FRC_HI = 51;
  // double extended layout
  localparam int XP_TOP    = 85;
  localparam int XP_SIGN   = 79;
  localparam int XP_EXP_HI = 78;
  localparam int XP_EXP_LO = 64;
  localparam int XP_INT    = 63;
  localparam int XP_FRC_HI = 62;
  localparam int FP_EXP_W  = 15;
  localparam int FP_FRC_W  = 63;
  // instruction stream
  localparam int DESC_REG_LO  = 0;
  localparam int DESC_MODE_LO = 4;
  localparam int NIB_W        = 4;
  localparam int MAX_IMM      = 4;
  localparam int CNT_W        = 3;
  typedef enum logic [1:0] {
    IS_IDLE = 2'h0,
    IS_OPC2 = 2'h1,
    IS_DATA = 2'h2
  } ofeu_istate_t;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// file: verilog/ofeu_field_extract.sv
`timescale 1ns/1ps
`default_nettype none
module ofeu_field_extract (
  // source word and field selection
  input  wire logic [31:0] word_in,
  input  wire logic [4:0]  offset_in,
  input  wire logic [4:0]  width_in,
  // extracted field, zero above its top bit
  output logic      [31:0] field_out,
  output logic      [31:0] mask_out
);
  logic [63:0] doubled;
  logic [63:0] shifted;
  logic [31:0] rotated;

  always_comb begin
    // bits past 31 come back in from bit 0 of the same word
    doubled = {word_in, word_in};
    shifted = doubled >> offset_in;
    rotated = shifted[31:0];
    mask_out = ~(32'hFFFF_FFFE << width_in);
    field_out = rotated & mask_out;
  end
endmodule
`default_nettype wire

// file: verilog/ofeu_core.sv
// Notes on behaviour
// - byte is eight bits, any address
// - halfword sixteen bits, even addresses only
// - word thirty-two bits, addresses multiple of four
// - all float operands four-byte aligned
// - single: sign 31, exponent 30:23
// - double: sign 63, exponent 62:52
// - extended: sign 79, exponent, integer bit 63
// - signed or unsigned, two's complement
// - offset bit becomes field bit zero
// - field length is width plus one
// - field wraps inside its own word
// - memory data most significant byte first
// - results always full thirty-two bits
// - signed loads sign extend, byte or halfword
// - unsigned loads zero extend, byte or halfword
// - byte source zero extends unless expanded
// - halfword source sign extends unless expanded
// - instruction: one/two opcode bytes, operands
// - operand is descriptor plus data bytes
// - immediate data least significant byte first
// - descriptor: register low, mode high nibble
`timescale 1ns/1ps
`default_nettype none
module ofeu_core (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // operand request
  input  wire logic        req_valid_in,
  input  wire logic [2:0]  req_op_in,
  input  wire logic [1:0]  req_size_in,
  input  wire logic        req_signed_in,
  input  wire logic        req_expand_in,
  input  wire logic [31:0] req_addr_in,
  input  wire logic [31:0] req_word_in,
  input  wire logic [4:0]  req_offset_in,
  input  wire logic [4:0]  req_width_in,
  input  wire logic [1:0]  req_fpfmt_in,
  input  wire logic [31:0] req_word1_in,
  input  wire logic [31:0] req_word2_in,
  // operand result
  output logic             res_valid_out,
  output logic [31:0]      res_data_out,
  output logic             res_align_err_out,
  output logic [31:0]      st_data_out,
  output logic [3:0]       st_be_out,
  output logic             fp_sign_out,
  output logic [14:0]      fp_exp_out,
  output logic             fp_int_out,
  output logic [62:0]      fp_frac_out,
  // instruction byte stream
  input  wire logic        ib_valid_in,
  input  wire logic [7:0]  ib_byte_in,
  input  wire logic        ib_opc_in,
  input  wire logic        ib_opc2_in,
  input  wire logic        ib_desc_in,
  input  wire logic [2:0]  ib_len_in,
  // decoded instruction pieces
  output logic             opc_valid_out,
  output logic [15:0]      opc_out,
  output logic             opd_valid_out,
  output logic [3:0]       opd_mode_out,
  output logic [3:0]       opd_reg_out,
  output logic [31:0]      opd_imm_out,
  output logic [2:0]       opd_len_out,
  output logic             ib_err_out
);
  typedef struct packed {
    logic                  res_valid;
    logic [31:0]           res_data;
    logic                  align_err;
    logic [31:0]           st_data;
    logic [3:0]            st_be;
    logic                  fp_sign;
    logic [14:0]           fp_exp;
    logic                  fp_int;
    logic [62:0]           fp_frac;
    ofeu_pkg::ofeu_istate_t ist;
    logic                  opc_valid;
    logic [15:0]           opc;
    logic                  opd_valid;
    logic [3:0]            opd_mode;
    logic [3:0]            opd_reg;
    logic [31:0]           opd_imm;
    logic [2:0]            opd_len;
    logic [2:0]            got;
    logic                  ib_err;
  } ofeu_state_t;

  ofeu_state_t st;
  ofeu_state_t next_st;

  logic [31:0] field_word;
  logic [31:0] field_mask;
  logic [7:0]  lane_byte;
  logic [15:0] lane_half;
  logic        ext_signed;
  logic        misaligned;
  logic [63:0] dbl;
  logic [85:0] ext;
  logic [31:0] ext_val;

  ofeu_field_extract u_field (
    .word_in   (req_word_in),
    .offset_in (req_offset_in),
    .width_in  (req_width_in),
    .field_out (field_word),
    .mask_out  (field_mask)
  );

  // lane of the addressed unit inside a big-endian word
  always_comb begin
    case (req_addr_in[1:0])
      2'h0: lane_byte = req_word_in[31:24];
      2'h1: lane_byte = req_word_in[23:16];
      2'h2: lane_byte = req_word_in[15:8];
      default: lane_byte = req_word_in[7:0];
    endcase
    case (req_addr_in[1])
      1'b0: lane_half = req_word_in[31:16];
      default: lane_half = req_word_in[15:0];
    endcase
  end

  wire logic [3:0] lane_be;

  // store byte enables, bit 3 is the lane at the lowest address
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic en;
    always_comb begin
      case (req_size_in)
        ofeu_pkg::SZ_BYTE: en = req_addr_in[1:0] == 2'(3 - g);
        ofeu_pkg::SZ_HALF: en = req_addr_in[1] == (g < 2);
        default: en = 1'b1;
      endcase
    end
    assign lane_be[g] = en;
  end

  // extension source and mode
  always_comb begin
    ext_signed = req_signed_in;
    if (req_op_in == ofeu_pkg::OP_REGSRC && !req_expand_in) begin
      ext_signed = (req_size_in == ofeu_pkg::SZ_HALF);
    end
    ext_val = req_word_in;
    case (req_size_in)
      ofeu_pkg::SZ_BYTE: begin
        if (req_op_in == ofeu_pkg::OP_LOAD) begin
          ext_val = {{24{ext_signed & lane_byte[7]}}, lane_byte};
        end else begin
          ext_val = {{24{ext_signed & req_word_in[7]}},
                     req_word_in[7:0]};
        end
      end
      ofeu_pkg::SZ_HALF: begin
        if (req_op_in == ofeu_pkg::OP_LOAD) begin
          ext_val = {{16{ext_signed & lane_half[15]}}, lane_half};
        end else begin
          ext_val = {{16{ext_signed & req_word_in[15]}},
                     req_word_in[15:0]};
        end
      end
      default: ext_val = req_word_in;
    endcase
  end

  // alignment of the addressed unit
  always_comb begin
    case (req_size_in)
      ofeu_pkg::SZ_BYTE: misaligned = 1'b0;
      ofeu_pkg::SZ_HALF: misaligned = req_addr_in[0];
      default: misaligned = |req_addr_in[1:0];
    endcase
    if (req_op_in == ofeu_pkg::OP_FLOAT) begin
      misaligned = |req_addr_in[1:0];
    end
    if (req_op_in == ofeu_pkg::OP_REGSRC ||
        req_op_in == ofeu_pkg::OP_FIELD) begin
      misaligned = 1'b0;
    end
  end

  // float words arrive first word most significant
  always_comb begin
    dbl = {req_word_in, req_word1_in};
    ext = {req_word_in[ofeu_pkg::XP_TOP-64:0], req_word1_in, req_word2_in};
  end

  always_comb begin
    next_st = st;
    next_st.res_valid = 1'b0;
    next_st.opc_valid = 1'b0;
    next_st.opd_valid = 1'b0;
    if (req_valid_in) begin
      next_st.res_valid = 1'b1;
      next_st.align_err = misaligned;
      next_st.res_data = ofeu_pkg::RST_WORD;
      next_st.st_be = 4'h0;
      case (req_op_in)
        ofeu_pkg::OP_LOAD,
        ofeu_pkg::OP_REGSRC: begin
          if (!misaligned) begin
            next_st.res_data = ext_val;
          end
        end
        ofeu_pkg::OP_STORE: begin
          next_st.res_data = req_word_in;
          if (!misaligned) begin
            next_st.st_be = lane_be;
            case (req_size_in)
              ofeu_pkg::SZ_BYTE: begin
                next_st.st_data = {4{req_word_in[7:0]}};
              end
              ofeu_pkg::SZ_HALF: begin
                next_st.st_data = {2{req_word_in[15:0]}};
              end
              default: begin
                next_st.st_data = req_word_in;
              end
            endcase
          end
        end
        ofeu_pkg::OP_FIELD: begin
          next_st.res_data = field_word;
        end
        ofeu_pkg::OP_FLOAT: begin
          next_st.fp_int = 1'b0;
          case (req_fpfmt_in)
            ofeu_pkg::FP_SINGLE: begin
              next_st.fp_sign = req_word_in[ofeu_pkg::SP_SIGN];
              next_st.fp_exp = {7'h00, req_word_in[
                ofeu_pkg::SP_EXP_HI:ofeu_pkg::SP_EXP_LO]};
              next_st.fp_frac = {40'h0,
                req_word_in[ofeu_pkg::SP_FRC_HI:0]};
            end
            ofeu_pkg::FP_DOUBLE: begin
              next_st.fp_sign = dbl[ofeu_pkg::DP_SIGN];
              next_st.fp_exp = {4'h0,
                dbl[ofeu_pkg::DP_EXP_HI:ofeu_pkg::DP_EXP_LO]};
              next_st.fp_frac = {11'h000, dbl[ofeu_pkg::DP_FRC_HI:0]};
            end
            default: begin
              next_st.fp_sign = ext[ofeu_pkg::XP_SIGN];
              next_st.fp_exp = ext[ofeu_pkg::XP_EXP_HI:ofeu_pkg::XP_EXP_LO];
              next_st.fp_int = ext[ofeu_pkg::XP_INT];
              next_st.fp_frac = ext[ofeu_pkg::XP_FRC_HI:0];
            end
          endcase
          next_st.res_data = req_word_in;
        end
        default: begin
          next_st.align_err = 1'b1;
        end
      endcase
    end

    // instruction byte stream
    if (ib_valid_in) begin
      case (st.ist)
        ofeu_pkg::IS_IDLE: begin
          if (ib_opc_in) begin
            next_st.opc = {8'h00, ib_byte_in};
            next_st.ib_err = 1'b0;
            if (ib_opc2_in) begin
              next_st.ist = ofeu_pkg::IS_OPC2;
            end else begin
              next_st.opc_valid = 1'b1;
            end
          end else if (ib_desc_in) begin
            next_st.opd_reg = ib_byte_in[ofeu_pkg::DESC_REG_LO +:
                                         ofeu_pkg::NIB_W];
            next_st.opd_mode = ib_byte_in[ofeu_pkg::DESC_MODE_LO +:
                                          ofeu_pkg::NIB_W];
            next_st.opd_imm = ofeu_pkg::RST_WORD;
            next_st.got = 3'h0;
            next_st.ib_err = 1'b0;
            if (ib_len_in > 3'(ofeu_pkg::MAX_IMM)) begin
              next_st.ib_err = 1'b1;
              next_st.opd_len = 3'(ofeu_pkg::MAX_IMM);
            end else begin
              next_st.opd_len = ib_len_in;
            end
            if (ib_len_in == 3'h0) begin
              next_st.opd_valid = 1'b1;
            end else begin
              next_st.ist = ofeu_pkg::IS_DATA;
            end
          end else begin
            next_st.ib_err = 1'b1;
          end
        end
        ofeu_pkg::IS_OPC2: begin
          next_st.opc = {st.opc[7:0], ib_byte_in};
          next_st.opc_valid = 1'b1;
          next_st.ist = ofeu_pkg::IS_IDLE;
        end
        ofeu_pkg::IS_DATA: begin
          case (st.got[1:0])
            2'h0: next_st.opd_imm[7:0] = ib_byte_in;
            2'h1: next_st.opd_imm[15:8] = ib_byte_in;
            2'h2: next_st.opd_imm[23:16] = ib_byte_in;
            default: next_st.opd_imm[31:24] = ib_byte_in;
          endcase
          next_st.got = st.got + 3'h1;
          if (st.got + 3'h1 == st.opd_len) begin
            next_st.opd_valid = 1'b1;
            next_st.ist = ofeu_pkg::IS_IDLE;
          end
        end
        default: begin
          next_st.ist = ofeu_pkg::IS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state
  assign res_valid_out     = st.res_valid;
  assign res_data_out      = st.res_data;
  assign res_align_err_out = st.align_err;
  assign st_data_out       = st.st_data;
  assign st_be_out         = st.st_be;
  assign fp_sign_out       = st.fp_sign;
  assign fp_exp_out        = st.fp_exp;
  assign fp_int_out        = st.fp_int;
  assign fp_frac_out       = st.fp_frac;
  assign opc_valid_out     = st.opc_valid;
  assign opc_out           = st.opc;
  assign opd_valid_out     = st.opd_valid;
  assign opd_mode_out      = st.opd_mode;
  assign opd_reg_out       = st.opd_reg;
  assign opd_imm_out       = st.opd_imm;
  assign opd_len_out       = st.opd_len;
  assign ib_err_out        = st.ib_err;
endmodule
`default_nettype wire

// file: dv/ofeu_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ofeu_core_asserts (
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // request
  input wire logic        req_valid_in,
  input wire logic [2:0]  req_op_in,
  input wire logic [1:0]  req_size_in,
  input wire logic        req_signed_in,
  input wire logic        req_expand_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [31:0] req_word_in,
  input wire logic [1:0]  req_fpfmt_in,
  input wire logic [31:0] req_word1_in,
  // results
  input wire logic        res_valid_out,
  input wire logic [31:0] res_data_out,
  input wire logic        res_align_err_out,
  input wire logic        fp_sign_out,
  input wire logic [14:0] fp_exp_out,
  input wire logic [62:0] fp_frac_out,
  input wire logic        opd_valid_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // request copies for the result cycle
  logic [31:0] w0;
  logic [31:0] w1;
  logic [7:0]  lb;
  wire  [7:0]  lane = req_word_in[8*(3-req_addr_in[1:0]) +: 8];
  wire         ld = req_valid_in && req_op_in == ofeu_pkg::OP_LOAD;
  wire         rs = req_valid_in && req_op_in == ofeu_pkg::OP_REGSRC;
  wire         fl = req_valid_in && req_op_in == ofeu_pkg::OP_FLOAT;
  wire         al = req_addr_in[1:0] == 2'h0;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      w0 <= 32'h0;
      w1 <= 32'h0;
      lb <= 8'h0;
    end else begin
      w0 <= req_word_in;
      w1 <= req_word1_in;
      lb <= lane;
    end
  end
  a_result_next: assert property (
    req_valid_in |=> res_valid_out) else $error("no result pulse");
  a_byte_zero_ext: assert property (
    ld && req_size_in == 2'h0 && !req_signed_in
    |=> res_data_out == {24'h0, lb}) else $error("byte load wrong");
  a_byte_sign_ext: assert property (
    ld && req_size_in == 2'h0 && req_signed_in
    |=> res_data_out == {{24{lb[7]}}, lb}) else $error("signed byte");
  a_half_misalign: assert property (
    ld && req_size_in == 2'h1 && req_addr_in[0]
    |=> res_align_err_out && res_data_out == 32'h0)
    else $error("odd half accepted");
  a_word_misalign: assert property (
    ld && req_size_in == 2'h2 && !al |=> res_align_err_out)
    else $error("unaligned word accepted");
  a_float_align: assert property (
    fl && !al |=> res_align_err_out) else $error("unaligned float");
  a_single_fields: assert property (
    fl && al && req_fpfmt_in == 2'h0 |=> fp_sign_out == w0[31] &&
    fp_exp_out == {7'h0, w0[30:23]} && fp_frac_out == {40'h0, w0[22:0]})
    else $error("single unpack wrong");
  a_double_fields: assert property (
    fl && al && req_fpfmt_in == 2'h1 |=> fp_exp_out == {4'h0, w0[30:20]}
    && fp_frac_out == {11'h0, w0[19:0], w1}) else $error("double unpack");
  a_reg_byte_src: assert property (
    rs && req_size_in == 2'h0 && !req_expand_in
    |=> res_data_out == {24'h0, w0[7:0]}) else $error("byte source");
  a_reg_half_src: assert property (
    rs && req_size_in == 2'h1 && !req_expand_in
    |=> res_data_out == {{16{w0[15]}}, w0[15:0]}) else $error("half source");
  c_load: cover property (ld ##1 res_valid_out);
  c_ext_float: cover property (fl && req_fpfmt_in == 2'h2);
  c_operand: cover property (opd_valid_out);
endmodule
bind ofeu_core ofeu_core_asserts u_chk (
  .clk_sys_in, .rst_in, .req_valid_in, .req_op_in, .req_size_in,
  .req_signed_in, .req_expand_in, .req_addr_in, .req_word_in,
  .req_fpfmt_in, .req_word1_in, .res_valid_out, .res_data_out,
  .res_align_err_out, .fp_sign_out, .fp_exp_out, .fp_frac_out,
  .opd_valid_out
);
`default_nettype wire

// file: dv/ofeu_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ofeu_mem_model;
  // byte wide store, any byte address
  logic [7:0] mem [0:31];
  initial for (int i = 0; i < 32; i++) mem[i] = 8'h0;
  function automatic void put_byte(input logic [4:0] a, input logic [7:0] b);
    mem[a] = b;
  endfunction
  // data: most significant byte at lowest address
  function automatic void put_word(input logic [4:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) mem[a+i] = w[31-8*i -: 8];
  endfunction
  // immediates: least significant byte first
  function automatic void put_imm(input logic [4:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) mem[a+i] = w[8*i +: 8];
  endfunction
  function automatic logic [31:0] rd_word(input logic [4:0] a);
    logic [4:0] b;
    b = {a[4:2], 2'h0};
    return {mem[b], mem[b+1], mem[b+2], mem[b+3]};
  endfunction
  function automatic logic [7:0] rdb(input logic [4:0] a);
    return mem[a];
  endfunction
endmodule
`default_nettype wire

// file: dv/operand_format_extension_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module operand_format_extension_unit_tb;
  logic        clk_sys_in, rst_in, req_valid_in, req_signed_in;
  logic        req_expand_in, ib_valid_in, ib_opc_in, ib_opc2_in, ib_desc_in;
  logic [2:0]  req_op_in, ib_len_in, opd_len_out;
  logic [1:0]  req_size_in, req_fpfmt_in;
  logic [31:0] req_addr_in, req_word_in, req_word1_in, req_word2_in;
  logic [4:0]  req_offset_in, req_width_in;
  logic [7:0]  ib_byte_in;
  logic        res_valid_out, res_align_err_out, fp_sign_out, fp_int_out;
  logic        opc_valid_out, opd_valid_out, ib_err_out;
  logic [31:0] res_data_out, st_data_out, opd_imm_out;
  logic [3:0]  st_be_out, opd_mode_out, opd_reg_out;
  logic [14:0] fp_exp_out;
  logic [62:0] fp_frac_out;
  logic [15:0] opc_out;
  int          failures = 0;
  int          samples_checked = 0;
  ofeu_mem_model u_mem ();
  ofeu_core DUT (
    .clk_sys_in, .rst_in, .req_valid_in, .req_op_in, .req_size_in,
    .req_signed_in, .req_expand_in, .req_addr_in, .req_word_in,
    .req_offset_in, .req_width_in, .req_fpfmt_in, .req_word1_in,
    .req_word2_in, .res_valid_out, .res_data_out, .res_align_err_out,
    .st_data_out, .st_be_out, .fp_sign_out, .fp_exp_out, .fp_int_out,
    .fp_frac_out, .ib_valid_in, .ib_byte_in, .ib_opc_in, .ib_opc2_in,
    .ib_desc_in, .ib_len_in, .opc_valid_out, .opc_out, .opd_valid_out,
    .opd_mode_out, .opd_reg_out, .opd_imm_out, .opd_len_out, .ib_err_out
  );
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic req(input logic [2:0] op, input logic [1:0] sz,
                     input logic sg, input logic ex,
                     input logic [31:0] a, input logic [31:0] w);
    @(posedge clk_sys_in);
    #1;
    {req_valid_in, req_op_in, req_size_in} = {1'b1, op, sz};
    {req_signed_in, req_expand_in, req_addr_in, req_word_in} = {sg, ex, a, w};
    @(posedge clk_sys_in);
    #1;
    req_valid_in = 1'b0;
    chk(res_valid_out, 1'b1);
    @(posedge clk_sys_in);
    #1;
    chk(res_valid_out, 1'b0);
  endtask
  task automatic ld(input logic [1:0] sz, input int a, input logic sg);
    req(ofeu_pkg::OP_LOAD, sz, sg, 1'b0, 32'(a), u_mem.rd_word(5'(a)));
  endtask
  task automatic t_load;
    logic [31:0] w;
    logic [15:0] h;
    u_mem.put_word(5'h04, 32'h12345678);
    u_mem.put_word(5'h08, 32'h89ABCDEF);
    for (int a = 4; a < 12; a++) begin
      w = a < 8 ? 32'h12345678 : 32'h89ABCDEF;
      h = w[16*(1-(a%4)/2) +: 16];
      ld(ofeu_pkg::SZ_BYTE, a, 1'b0);
      chk(res_data_out, {24'h0, w[8*(3-a%4) +: 8]});
      ld(ofeu_pkg::SZ_BYTE, a, 1'b1);
      chk(res_data_out[31:8], {24{w[8*(3-a%4)+7]}});
      ld(ofeu_pkg::SZ_HALF, a, 1'b1);
      chk(res_align_err_out, a % 2);
      if (a % 2 == 0) chk(res_data_out, {{16{h[15]}}, h});
      else chk(res_data_out, 32'h0);
      ld(ofeu_pkg::SZ_WORD, a, 1'b0);
      chk(res_align_err_out, a % 4 != 0);
      if (a % 4 == 0) chk(res_data_out, w);
    end
    $display("load test done");
  endtask
  task automatic rs(input logic [1:0] sz, input logic ex, input logic sg,
                    input logic [31:0] e);
    req(ofeu_pkg::OP_REGSRC, sz, sg, ex, 32'h0, 32'h123480F7);
    chk(res_data_out, e);
  endtask
  task automatic t_regsrc;
    rs(ofeu_pkg::SZ_BYTE, 1'b0, 1'b1, 32'h000000F7);
    rs(ofeu_pkg::SZ_BYTE, 1'b1, 1'b1, 32'hFFFFFFF7);
    rs(ofeu_pkg::SZ_HALF, 1'b0, 1'b0, 32'hFFFF80F7);
    rs(ofeu_pkg::SZ_HALF, 1'b1, 1'b0, 32'h000080F7);
    rs(ofeu_pkg::SZ_WORD, 1'b0, 1'b0, 32'h123480F7);
    $display("register source test done");
  endtask
  task automatic t_field;
    int off [5] = '{6, 28, 0, 31, 17};
    int wid [5] = '{9, 7, 31, 0, 31};
    logic [31:0] e;
    logic [31:0] src = 32'hA5C3F00F;
    for (int k = 0; k < 5; k++) begin
      e = 32'h0;
      for (int i = 0; i <= wid[k]; i++) e[i] = src[(off[k] + i) % 32];
      req_offset_in = 5'(off[k]);
      req_width_in = 5'(wid[k]);
      req(ofeu_pkg::OP_FIELD, 2'h2, 1'b0, 1'b0, 32'h0, 32'hA5C3F00F);
      chk(res_data_out, e);
    end
    $display("bit field test done");
  endtask
  task automatic st(input logic [1:0] sz, input logic [31:0] a,
                    input logic [3:0] be);
    req(ofeu_pkg::OP_STORE, sz, 1'b0, 1'b0, a, 32'h12345678);
    chk(st_be_out, be);
  endtask
  task automatic t_store;
    st(ofeu_pkg::SZ_WORD, 32'h8, 4'hF);
    chk(st_data_out, 32'h12345678);
    st(ofeu_pkg::SZ_BYTE, 32'h9, 4'h4);
    st(ofeu_pkg::SZ_HALF, 32'hA, 4'h3);
    st(ofeu_pkg::SZ_HALF, 32'h9, 4'h0);
    st(ofeu_pkg::SZ_WORD, 32'h6, 4'h0);
    $display("store test done");
  endtask
  task automatic fp(input logic [1:0] f, input logic [31:0] a,
                    input logic [95:0] w, input logic [79:0] e);
    {req_fpfmt_in, req_word1_in, req_word2_in} = {f, w[63:0]};
    req(ofeu_pkg::OP_FLOAT, 2'h2, 1'b0, 1'b0, a, w[95:64]);
    chk(res_align_err_out, a[1:0] != 2'h0);
    if (a[1:0] == 2'h0) begin
      chk({fp_sign_out, fp_exp_out, fp_int_out, fp_frac_out}, e);
    end
  endtask
  task automatic t_float;
    fp(2'h0, 32'h0, {32'hC0490FDB, 64'h0}, {1'b1, 15'h80, 64'h490FDB});
    fp(2'h1, 32'h4, {64'h400921FB54442D18, 32'h0},
       {1'b0, 15'h400, 64'h921FB54442D18});
    fp(2'h2, 32'h8, 96'h003FC000_80000000_00000001,
       {1'b1, 15'h4000, 1'b1, 63'h1});
    fp(2'h0, 32'h2, 96'h0, 80'h0);
    $display("float test done");
  endtask
  task automatic ib(input int p, input logic o, input logic o2,
                    input logic d, input logic [2:0] l);
    @(posedge clk_sys_in);
    #1;
    {ib_valid_in, ib_opc_in, ib_opc2_in, ib_desc_in} = {1'b1, o, o2, d};
    {ib_byte_in, ib_len_in} = {u_mem.rdb(5'(p)), l};
  endtask
  task automatic ibe;
    @(posedge clk_sys_in);
    #1;
    ib_valid_in = 1'b0;
  endtask
  task automatic t_ibyte;
    u_mem.put_word(5'h10, 32'h301C4F00);
    u_mem.put_imm(5'h13, 32'h12345678);
    u_mem.put_word(5'h17, 32'h84520000);
    ib(16, 1'b1, 1'b1, 1'b0, 3'h0);
    ib(17, 1'b0, 1'b0, 1'b0, 3'h0);
    ibe;
    chk({opc_valid_out, opc_out}, {1'b1, 16'h301C});
    ib(18, 1'b0, 1'b0, 1'b1, 3'h4);
    for (int p = 19; p < 23; p++) ib(p, 1'b0, 1'b0, 1'b0, 3'h0);
    ibe;
    chk({opd_valid_out, opd_mode_out, opd_reg_out}, 9'h14F);
    chk({opd_imm_out, opd_len_out}, {32'h12345678, 3'h4});
    ib(23, 1'b1, 1'b0, 1'b0, 3'h0);
    ibe;
    chk({opc_valid_out, opc_out}, {1'b1, 16'h0084});
    ib(24, 1'b0, 1'b0, 1'b1, 3'h0);
    ibe;
    chk({opd_valid_out, opd_mode_out, opd_reg_out, opd_imm_out},
        {9'h152, 32'h0});
    ib(25, 1'b0, 1'b0, 1'b0, 3'h0);
    ibe;
    chk(ib_err_out, 1'b1);
    $display("instruction stream test done");
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {req_valid_in, req_op_in, req_size_in, req_signed_in, req_expand_in} = '0;
    {req_addr_in, req_word_in, req_word1_in, req_word2_in} = '0;
    {req_offset_in, req_width_in, req_fpfmt_in} = '0;
    {ib_valid_in, ib_byte_in, ib_opc_in, ib_opc2_in, ib_desc_in} = '0;
    ib_len_in = 3'h0;
    rst_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    t_load;
    t_regsrc;
    t_field;
    t_store;
    t_float;
    t_ibyte;
    finish_test;
  end
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    failures++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test;
  end
endmodule
`default_nettype wire
